// ===== line_code_map.svh
`ifndef LINE_CODE_MAP_SVH
`define LINE_CODE_MAP_SVH

// Register byte offsets within the block
`define LC_OFS_CTRL        4'h0
`define LC_OFS_DIV         4'h4
`define LC_OFS_STATUS      4'h8
`define LC_OFS_COUNT       4'hC

// Control fields
`define LC_CTRL_EN_BIT     0
`define LC_CTRL_POLAR_BIT  1
`define LC_CTRL_MODE_LSB   4
`define LC_CTRL_MODE_MSB   7

// Status fields
`define LC_ST_RUN_BIT      0
`define LC_ST_UNDER_BIT    1
`define LC_ST_POS_BIT      2
`define LC_ST_NEG_BIT      3
`define LC_ST_PHASE_LSB    4
`define LC_ST_PHASE_MSB    7

// Reset values
`define LC_MODE_RST        4'h5
`define LC_DIV_RST         16'h0009
`define LC_POLAR_RST       1'b0

// Mode codes in the control register
`define LC_CODE_LEVEL      4'h0
`define LC_CODE_INV_ONE    4'h1
`define LC_CODE_INV_ZERO   4'h2
`define LC_CODE_RZ         4'h3
`define LC_CODE_PPM        4'h4
`define LC_CODE_PW_THIRD   4'h5
`define LC_CODE_PW_QUART   4'h6
`define LC_CODE_TP_LEVEL   4'h7
`define LC_CODE_TP_MARK    4'h8
`define LC_CODE_TP_SPACE   4'h9

// Sub-bit grid: twelve ticks per bit period, phases 0..11
`define LC_PHASE_LAST      4'hB
`define LC_PHASE_MID       4'h6
`define LC_PHASE_Q1        4'h3
`define LC_PHASE_T1        4'h4
`define LC_PHASE_T2        4'h8
`define LC_PHASE_Q3        4'h9

`endif

// ===== line_code_pkg.sv
`default_nettype none

package line_code_pkg;

  // Active line code
  typedef enum logic [3:0] {
    MODE_LEVEL,
    MODE_INV_ONE,
    MODE_INV_ZERO,
    MODE_RZ,
    MODE_PULSE_POSITION,
    MODE_PULSE_WIDTH_THIRD,
    MODE_PULSE_WIDTH_QUARTER,
    MODE_TWO_PHASE_LEVEL,
    MODE_TWO_PHASE_MARK,
    MODE_TWO_PHASE_SPACE
  } mode_e;

  // Three-valued line level: pos, neg or neither (zero)
  typedef struct packed {
    logic pos;
    logic neg;
  } line_s;

  // Register write strobe with its target and data
  typedef struct packed {
    logic        en;
    logic [3:0]  ofs;
    logic [31:0] data;
  } regwr_s;

endpackage
`default_nettype wire

// ===== lc_ahb_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_code_map.svh"

module lc_ahb_slave
  import line_code_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // Register file side
  input  wire logic [31:0] rd_data,
  output      logic [3:0]  rd_ofs,
  output      regwr_s      wr
);

  logic        wpend_r;
  logic [3:0]  wofs_r;
  logic        accept;
  logic        mapped;
  logic        word_sz;

  // Address phase decode
  assign accept    = hsel & htrans[1] & hready;
  assign mapped    = (haddr[11:4] == 8'h00);
  assign word_sz   = (hsize == 3'h2);
  assign rd_ofs    = {haddr[3:2], 2'h0};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Write strobe lives in the data phase
  assign wr.en   = wpend_r;
  assign wr.ofs  = wofs_r;
  assign wr.data = hwdata;

  // Capture address phase; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_r <= 1'b0;
      wofs_r  <= 4'h0;
      hrdata  <= 32'h0000_0000;
    end else begin
      wpend_r <= accept & hwrite & word_sz & mapped;
      wofs_r  <= {haddr[3:2], 2'h0};
      if (accept && !hwrite) begin
        hrdata <= mapped ? rd_data : 32'h0000_0000; // Unmapped reads zero
      end
    end
  end

endmodule // lc_ahb_slave
`default_nettype wire

// ===== lc_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none

module lc_tick_gen (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] div,
  // Sub-bit tick, one hclk wide
  output      logic        tick
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        wrap;

  // One tick every div+1 clocks
  assign wrap    = (cnt_r >= div);
  assign tick    = run & wrap;
  assign cnt_nxt = (!run || wrap) ? 16'h0000 : 16'(cnt_r + 16'h0001);

  // Divider counter, parked at zero while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // lc_tick_gen
`default_nettype wire

// ===== line_code_encoder.sv
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "line_code_map.svh"

module line_code_encoder
  import line_code_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // Serial bit source
  input  wire logic        bit_data,
  input  wire logic        bit_valid,
  output      logic        bit_ready,
  // Line driver
  output var  line_s       line_out
);

  // Map a control field code to a mode; unknown codes fall back to default
  function automatic mode_e decode_mode(input logic [3:0] code);
    mode_e m;
    m = MODE_PULSE_WIDTH_THIRD;
    case (code)
      `LC_CODE_LEVEL:     m = MODE_LEVEL;
      `LC_CODE_INV_ONE:   m = MODE_INV_ONE;
      `LC_CODE_INV_ZERO:  m = MODE_INV_ZERO;
      `LC_CODE_RZ:        m = MODE_RZ;
      `LC_CODE_PPM:       m = MODE_PULSE_POSITION;
      `LC_CODE_PW_THIRD:  m = MODE_PULSE_WIDTH_THIRD;
      `LC_CODE_PW_QUART:  m = MODE_PULSE_WIDTH_QUARTER;
      `LC_CODE_TP_LEVEL:  m = MODE_TWO_PHASE_LEVEL;
      `LC_CODE_TP_MARK:   m = MODE_TWO_PHASE_MARK;
      `LC_CODE_TP_SPACE:  m = MODE_TWO_PHASE_SPACE;
      default:            m = MODE_PULSE_WIDTH_THIRD;
    endcase
    return m;
  endfunction

  // Codes whose held level toggles at every bit boundary
  function automatic logic is_transition_code(input mode_e m);
    logic t;
    t = 1'b0;
    case (m)
      MODE_TWO_PHASE_MARK, MODE_TWO_PHASE_SPACE: t = 1'b1;
      default:                                   t = 1'b0;
    endcase
    return t;
  endfunction

  // Two-level codes may swing negative; pulse codes stay unipolar
  function automatic logic is_two_level(input mode_e m);
    logic t;
    t = 1'b0;
    case (m)
      MODE_LEVEL, MODE_INV_ONE, MODE_INV_ZERO: t = 1'b1;
      MODE_TWO_PHASE_LEVEL:                    t = 1'b1;
      default:                                 t = is_transition_code(m);
    endcase
    return t;
  endfunction

  // Register file state
  logic        enable_r;
  logic        polar_r;
  logic [3:0]  mode_code_r;
  logic [15:0] div_r;
  logic        underrun_r;
  logic [15:0] count_r;
  logic        enable_nxt;
  logic        polar_nxt;
  logic [3:0]  mode_code_nxt;
  logic [15:0] div_nxt;
  logic        underrun_nxt;
  logic [15:0] count_nxt;

  // Encoder state
  logic        started_r;
  logic [3:0]  phase_r;
  logic        bit_r;
  logic        lvl_r;
  logic        started_nxt;
  logic [3:0]  phase_nxt;
  logic        bit_nxt;
  logic        lvl_nxt;
  line_s       line_nxt;

  // Bus side wires
  regwr_s      wr;
  logic [3:0]  rd_ofs;
  logic [31:0] rd_data;
  logic        wr_ctrl;
  logic        wr_div;
  logic        wr_status;

  // Timing and code wires
  logic        tick;
  mode_e       mode;
  logic        bit_start;
  logic        mid_tick;
  logic        next_bit;
  logic        tog_start;
  logic        tog_mid;
  logic        high;
  logic        two_level;
  logic        second_half;

  lc_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_data   (rd_data),
    .rd_ofs    (rd_ofs),
    .wr        (wr)
  );

  lc_tick_gen u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (enable_r),
    .div     (div_r),
    .tick    (tick)
  );

  // Write target decode
  assign wr_ctrl   = wr.en & (wr.ofs == `LC_OFS_CTRL);
  assign wr_div    = wr.en & (wr.ofs == `LC_OFS_DIV);
  assign wr_status = wr.en & (wr.ofs == `LC_OFS_STATUS);

  // Control register: mode and polarity only take while stopped
  assign enable_nxt    = wr_ctrl ? wr.data[`LC_CTRL_EN_BIT] : enable_r;
  assign polar_nxt     = (wr_ctrl && !enable_r) ?
                         wr.data[`LC_CTRL_POLAR_BIT] : polar_r;
  assign mode_code_nxt = (wr_ctrl && !enable_r) ?
                         wr.data[`LC_CTRL_MODE_MSB:`LC_CTRL_MODE_LSB] : mode_code_r;
  assign div_nxt       = (wr_div && !enable_r) ? wr.data[15:0] : div_r;

  // Underrun is sticky; a new underrun beats a write-one clear
  assign underrun_nxt = (bit_start & ~bit_valid) |
                        (underrun_r & ~(wr_status & wr.data[`LC_ST_UNDER_BIT]));

  // Bits sent since reset, wrapping
  assign count_nxt = bit_start ? 16'(count_r + 16'h0001) : count_r;

  // Read data selection
  assign rd_data = (rd_ofs == `LC_OFS_CTRL)   ? {24'h00_0000, mode_code_r, 2'h0, polar_r,
                                                  enable_r} :
                   (rd_ofs == `LC_OFS_DIV)    ? {16'h0000, div_r} :
                   (rd_ofs == `LC_OFS_STATUS) ? {24'h00_0000, phase_r, line_out.neg,
                                                  line_out.pos, underrun_r, started_r} :
                                                {16'h0000, count_r};

  // Active mode from the static control field
  assign mode = decode_mode(mode_code_r);

  // Bit boundary on the tick that closes phase 11, or the first tick after start
  assign bit_start = enable_r & tick & (~started_r | (phase_r == `LC_PHASE_LAST));
  assign mid_tick  = enable_r & tick & started_r & (phase_r == 4'(`LC_PHASE_MID - 4'h1));
  assign bit_ready = bit_start;
  assign next_bit  = bit_valid & bit_data;

  // Held-level toggles at bit start
  assign tog_start = bit_start &
                     (((mode == MODE_INV_ONE) & next_bit) |
                      ((mode == MODE_INV_ZERO) & ~next_bit) |
                      (started_r & is_transition_code(mode)));

  // Held-level toggles at the bit midpoint
  assign tog_mid = mid_tick &
                   (((mode == MODE_TWO_PHASE_MARK) & bit_r) |
                    ((mode == MODE_TWO_PHASE_SPACE) & ~bit_r));

  // Sequencing of phase, bit and held level
  assign started_nxt = enable_r & (started_r | tick);
  assign phase_nxt   = !enable_r ? 4'h0 :
                       bit_start ? 4'h0 :
                       tick      ? 4'(phase_r + 4'h1) : phase_r;
  assign bit_nxt     = !enable_r ? 1'b0 : (bit_start ? next_bit : bit_r);
  assign lvl_nxt     = !enable_r ? 1'b0 : (lvl_r ^ (tog_start | tog_mid));
  assign second_half = (phase_r >= `LC_PHASE_MID);

  // High or low for the current phase of the current bit
  always_comb begin
    high = 1'b0;
    case (mode)
      MODE_LEVEL: begin
        high = bit_r;
      end
      MODE_INV_ONE, MODE_INV_ZERO: begin
        high = lvl_r;
      end
      MODE_RZ: begin
        high = bit_r & ~second_half;
      end
      MODE_PULSE_POSITION: begin
        high = bit_r ? (second_half & (phase_r < `LC_PHASE_Q3)) :
                       (phase_r < `LC_PHASE_Q1);
      end
      MODE_PULSE_WIDTH_THIRD: begin
        high = bit_r ? (phase_r < `LC_PHASE_T2) : (phase_r < `LC_PHASE_T1);
      end
      MODE_PULSE_WIDTH_QUARTER: begin
        high = bit_r ? (phase_r < `LC_PHASE_Q3) : (phase_r < `LC_PHASE_Q1);
      end
      MODE_TWO_PHASE_LEVEL: begin
        high = bit_r ^ second_half;
      end
      MODE_TWO_PHASE_MARK, MODE_TWO_PHASE_SPACE: begin
        high = lvl_r;
      end
      default: begin
        high = 1'b0;
      end
    endcase
  end

  // Only the two-level codes drive negative in polar form
  assign two_level = is_two_level(mode);

  // Three-valued line level
  assign line_nxt.pos = started_r & high;
  assign line_nxt.neg = started_r & ~high & two_level & polar_r;

  // Register file
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r    <= 1'b0;
      polar_r     <= `LC_POLAR_RST;
      mode_code_r <= `LC_MODE_RST;
      div_r       <= `LC_DIV_RST;
      underrun_r  <= 1'b0;
      count_r     <= 16'h0000;
    end else begin
      enable_r    <= enable_nxt;
      polar_r     <= polar_nxt;
      mode_code_r <= mode_code_nxt;
      div_r       <= div_nxt;
      underrun_r  <= underrun_nxt;
      count_r     <= count_nxt;
    end
  end

  // Encoder sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      started_r <= 1'b0;
      phase_r   <= 4'h0;
      bit_r     <= 1'b0;
      lvl_r     <= 1'b0;
    end else begin
      started_r <= started_nxt;
      phase_r   <= phase_nxt;
      bit_r     <= bit_nxt;
      lvl_r     <= lvl_nxt;
    end
  end

  // Line output registered so transitions are glitch-free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_out <= '0;
    end else begin
      line_out <= line_nxt;
    end
  end

endmodule // line_code_encoder
`default_nettype wire

// ===== line_code_checker.sv
`timescale 1ns/1ns
`default_nettype none

module line_code_checker
  import line_code_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Bit source and line
  input wire logic        bit_data,
  input wire logic        bit_valid,
  input wire logic        bit_ready,
  input wire line_s       line_out
);
  logic       wr_r;
  logic       en_r;
  logic       pol_r;
  logic [3:0] mode_r;
  logic       lvl;
  logic       inv;
  logic       pulse;

  // Mirror of the control word; mode and polarity locked while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r   <= 1'b0;
      en_r   <= 1'b0;
      pol_r  <= 1'b0;
      mode_r <= 4'h5;
    end else begin
      wr_r <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2 && haddr[11:2] == 10'h0;
      if (wr_r) begin
        en_r <= hwdata[0];
      end
      if (wr_r && !en_r) begin
        pol_r  <= hwdata[1];
        mode_r <= hwdata[7:4];
      end
    end
  end

  // Mode groups; unused codes behave as pulse width
  assign lvl   = mode_r == 4'h0 || mode_r == 4'h7;
  assign inv   = mode_r == 4'h1 || mode_r == 4'h2;
  assign pulse = mode_r > 4'h2 && mode_r != 4'h7 && mode_r != 4'h8 && mode_r != 4'h9;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Bit taken, then its first line level two clocks later
  sequence s_sym(g);
    g && bit_ready ##2 1'b1;
  endsequence

  AST_NEVER_BOTH: assert property (line_out != 2'b11)
    else $error("line driven positive and negative");
  AST_REQ_GAP: assert property (bit_ready |=> !bit_ready [*8])
    else $error("bit requests too close");
  AST_REQ_RUN: assert property (bit_ready |-> en_r)
    else $error("bit request while stopped");
  AST_IDLE_LOW: assert property (!en_r [*3] |-> line_out == 2'b00)
    else $error("line active while stopped");
  AST_LVL_START:
    assert property (s_sym(lvl) |-> line_out == {$past(bit_valid && bit_data, 2),
      pol_r && !$past(bit_valid && bit_data, 2)}) else $error("wrong level at bit start");
  AST_INV_START:
    assert property (s_sym(inv && !pol_r) |-> $changed(line_out) ==
      ($past(bit_valid && bit_data, 2) ^ (mode_r == 4'h2))) else $error("wrong toggle");
  AST_PULSE_START:
    assert property (s_sym(pulse) |-> line_out == {(mode_r == 4'h3) ? $past(bit_valid
      && bit_data, 2) : (mode_r == 4'h4) ? !$past(bit_valid && bit_data, 2) : 1'b1, 1'b0})
      else $error("wrong pulse start");
  AST_PULSE_POS: assert property (pulse |-> !line_out.neg)
    else $error("negative level in pulse code");
  AST_HOLD:
    assert property ((mode_r == 4'h0 || inv) && !pol_r && en_r && $past(en_r)
      && $changed(line_out) |-> $past(bit_ready, 2)) else $error("change inside a bit");
endmodule // line_code_checker

bind line_code_encoder line_code_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .bit_data, .bit_valid, .bit_ready, .line_out);

`default_nettype wire

// ===== bit_source_model.sv
`timescale 1ns/1ns
`default_nettype none

module bit_source_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Test control
  input  wire logic [15:0] pattern,
  input  wire logic        starve,
  // Encoder handshake
  input  wire logic        bit_ready,
  output      logic        bit_data,
  output      logic        bit_valid
);
  logic [3:0] idx_r;
  logic       last_r;

  // Step to the next pattern bit once the encoder takes one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r  <= 4'h0;
      last_r <= 1'b0;
    end else if (bit_ready) begin
      idx_r  <= idx_r + 4'h1;
      last_r <= bit_data;
    end
  end

  // Bit always on offer unless starved; a starved line shows no stale bit
  assign bit_valid = !starve;
  assign bit_data  = starve ? !last_r : pattern[idx_r];
endmodule // bit_source_model

`default_nettype wire

// ===== baseband_line_code_encoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module baseband_line_code_encoder_tb_top;
  import line_code_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic        hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        bit_data;
  logic        bit_valid;
  logic        bit_ready;
  line_s       line_out;
  logic        starve;
  logic [31:0] rd;
  int          n_fail;
  int          cmp_count;

  // Clock and single-slave ready
  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  line_code_encoder uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .bit_data, .bit_valid, .bit_ready, .line_out);
  bit_source_model src (.hclk, .hresetn, .pattern(16'hB2D4), .starve, .bit_ready,
    .bit_data, .bit_valid);

  // Compare and count
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Bounded wait for bus ready at a rising edge
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  // Register reset values and an unmapped word
  task automatic test_reset_values();
    logic [31:0] exp [5] = '{32'h50, 32'h9, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 32'(4 * i), 32'h0);
      check("reset read", rd, exp[i]);
    end
    $display("test reset values done");
  endtask

  // Configure one code, run nbits bits, check every sub-bit level, then stop
  task automatic run_mode(input logic [3:0] m, input logic pol, input int nbits);
    logic b;
    logic bn;
    logic held;
    logic hi;
    logic lo;
    int   i;
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h4, 32'h0);
    ahb(1'b1, 32'h0, {24'h0, m, 2'b00, pol, 1'b0});
    ahb(1'b1, 32'h0, {24'h0, m, 2'b00, pol, 1'b1});
    held = 1'b0;
    bn = 1'b0;
    i = 0;
    do begin
      @(negedge hclk);
      i++;
    end while (bit_ready !== 1'b1 && i < 200);
    check("first request", {31'h0, bit_ready}, 32'h1);
    if (bit_ready !== 1'b1) end_of_test();
    b = bit_valid & bit_data;
    @(negedge hclk);
    for (int k = 0; k < nbits; k++) begin
      for (int p = 0; p < 12; p++) begin
        @(negedge hclk);
        if (p == 0 && k > 0 && (m == 4'h8 || m == 4'h9)) held = ~held;
        if (p == 0 && m == 4'h1) held ^= b;
        if (p == 0 && m == 4'h2) held ^= ~b;
        if (p == 6 && m == 4'h8) held ^= b;
        if (p == 6 && m == 4'h9) held ^= ~b;
        case (m)
          4'h0: hi = b;
          4'h1, 4'h2, 4'h8, 4'h9: hi = held;
          4'h3: hi = b && p < 6;
          4'h4: hi = b ? (p >= 6 && p < 9) : p < 3;
          4'h6: hi = b ? p < 9 : p < 3;
          4'h7: hi = b ^ (p >= 6);
          default: hi = b ? p < 8 : p < 4;
        endcase
        lo = !hi && pol && (m < 4'h3 || (m > 4'h6 && m < 4'hA));
        check("line", {30'h0, line_out}, {30'h0, hi, lo});
        if (p == 10) begin
          check("bit request", {31'h0, bit_ready}, 32'h1);
          bn = bit_valid & bit_data;
        end
      end
      b = bn;
    end
    ahb(1'b1, 32'h0, 32'h0);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("idle line", {30'h0, line_out}, 32'h0);
  endtask

  // Every code in both polarities, plus an unused code
  task automatic test_modes();
    for (int k = 0; k < 22; k++) begin
      run_mode((k < 20) ? 4'(k / 2) : 4'hC, k[0], 8);
    end
    $display("test modes done");
  endtask

  // Starved source, sticky flag clear, writes refused while running
  task automatic test_underrun_lock();
    @(posedge hclk);
    starve <= 1'b1;
    run_mode(4'h0, 1'b0, 2);
    ahb(1'b0, 32'h8, 32'h0);
    check("underrun set", rd & 32'h2, 32'h2);
    starve <= 1'b0;
    ahb(1'b1, 32'h8, 32'h2);
    ahb(1'b0, 32'h8, 32'h0);
    check("underrun clear", rd & 32'h2, 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b1, 32'h0, 32'h33);
    ahb(1'b1, 32'h4, 32'h5);
    ahb(1'b0, 32'h0, 32'h0);
    check("locked control", rd, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    check("locked divider", rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h0);
    $display("test underrun and lock done");
  endtask

  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    starve = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset_values();
    test_modes();
    test_underrun_lock();
    end_of_test();
  end
endmodule // baseband_line_code_encoder_tb_top

`default_nettype wire
